//--- src/ccs_channel.sv
// clock-synchronous serial channel with AXI4-Lite register slave
// assumes one aclk domain; pins are synchronised inside
module ccs_channel
  import ccs_pkg::*;
(
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // axi write address
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [ADDR_W-1:0] s_axi_awaddr,
  // axi write data
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  // axi write response
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi read address
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  input logic [ADDR_W-1:0] s_axi_araddr,
  // axi read data
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // serial pins
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input logic serial_data_in,
  input logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe,
  // request pulses
  output logic tx_irq_req,
  output logic rx_irq_req
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wlane;
    logic [2:0] mode;
    logic cksrc;
    logic [1:0] divsel;
    logic od;
    logic cpol;
    logic msb;
    logic te;
    logic ti;
    logic re;
    logic ri;
    logic irs;
    logic crx;
    logic [7:0] txbuf;
    logic [7:0] rxbuf;
    logic [7:0] brg;
    logic ovr;
    logic framing_error_flag;
    logic per;
    logic shift_register_empty_flag;
    ccs_phase_e phase;
    logic [7:0] sh;
    logic [2:0] bits;
    logic txbit;
    logic sclk;
    logic ext_prev;
    logic txd_o;
    logic txd_oe;
    logic sclk_o;
    logic sclk_oe;
    logic tx_irq;
    logic rx_irq;
  } ccs_state_s;

  localparam ccs_state_s ST_RST = '{
    ti: RST_TI, shift_register_empty_flag: RST_SHIFT_REGISTER_EMPTY_FLAG, txbit: RST_LINE, sclk: RST_LINE,
    txd_o: RST_LINE, sclk_o: RST_LINE, phase: PH_OFF, default: '0};

  ccs_state_s r_reg;
  ccs_state_s r_next;
  logic [1:0] pins_q;
  logic brg_run;
  logic brg_tick;
  logic sync_mode;
  logic idle_lvl;
  logic edge_c;
  logic lead_c;
  logic drive_c;
  logic samp_c;
  logic start_c;
  logic done_c;
  logic store_c;
  logic wr_go;
  logic wr_hit;
  logic rd_go;
  logic rd_hit;
  logic rd_rx;
  logic [31:0] rd_data;
  logic [7:0] sh_in;

  // ------------------------------------------------------------
  // clock generation and pin synchronisers
  // ------------------------------------------------------------
  assign brg_run = (r_reg.phase == PH_SHIFT) && !r_reg.cksrc;

  ccs_brg u_brg (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(brg_run),
    .src_sel(r_reg.divsel),
    .divisor(r_reg.brg),
    .tick(brg_tick)
  );

  ccs_sync3 #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({transfer_clock_pin_in, serial_data_in}),
    .q(pins_q)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    rd_data = '0;
    rd_hit = 1'b1;
    edge_c = 1'b0;
    lead_c = 1'b0;
    drive_c = 1'b0;
    samp_c = 1'b0;
    start_c = 1'b0;
    done_c = 1'b0;
    store_c = 1'b0;
    sync_mode = (r_reg.mode == MODE_SYNC);
    idle_lvl = ~r_reg.cpol;
    r_next.tx_irq = 1'b0;
    r_next.rx_irq = 1'b0;
    // write channels taken in either order
    if (s_axi_awvalid && r_reg.awready)
    begin
      r_next.aw_have = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wready)
    begin
      r_next.w_have = 1'b1;
      r_next.wdata = s_axi_wdata[7:0];
      r_next.wlane = s_axi_wstrb[0];
    end
    if (r_reg.bvalid && s_axi_bready)
      r_next.bvalid = 1'b0;
    wr_go = r_next.aw_have && r_next.w_have && !r_reg.bvalid;
    wr_hit = (r_next.awaddr == OFF_TX) || (r_next.awaddr == OFF_RX)
      || (r_next.awaddr == OFF_BRG) || (r_next.awaddr == OFF_MODE)
      || (r_next.awaddr == OFF_CTLA) || (r_next.awaddr == OFF_CTLB)
      || (r_next.awaddr == OFF_SHARED_SERIAL_CONTROL);
    if (wr_go)
    begin
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    // read decode
    if (r_reg.rvalid && s_axi_rready)
      r_next.rvalid = 1'b0;
    rd_go = s_axi_arvalid && r_reg.arready;
    if (s_axi_araddr == OFF_TX)
      rd_data = '0;
    else if (s_axi_araddr == OFF_RX)
    begin
      rd_data[7:0] = r_reg.rxbuf;
      rd_data[OVR_BIT] = r_reg.ovr;
      rd_data[FER_BIT] = r_reg.framing_error_flag;
      rd_data[PER_BIT] = r_reg.per;
      rd_data[SUM_BIT] = r_reg.ovr | r_reg.framing_error_flag | r_reg.per;
    end
    else if (s_axi_araddr == OFF_BRG)
      rd_data[7:0] = r_reg.brg;
    else if (s_axi_araddr == OFF_MODE)
    begin
      rd_data[2:0] = r_reg.mode;
      rd_data[CKSRC_BIT] = r_reg.cksrc;
    end
    else if (s_axi_araddr == OFF_CTLA)
    begin
      rd_data[1:0] = r_reg.divsel;
      rd_data[SHIFT_REGISTER_EMPTY_FLAG_BIT] = r_reg.shift_register_empty_flag;
      rd_data[OD_BIT] = r_reg.od;
      rd_data[CPOL_BIT] = r_reg.cpol;
      rd_data[MSB_BIT] = r_reg.msb;
    end
    else if (s_axi_araddr == OFF_CTLB)
    begin
      rd_data[TE_BIT] = r_reg.te;
      rd_data[TI_BIT] = r_reg.ti;
      rd_data[RE_BIT] = r_reg.re;
      rd_data[RI_BIT] = r_reg.ri;
    end
    else if (s_axi_araddr == OFF_SHARED_SERIAL_CONTROL)
    begin
      rd_data[IRS_BIT] = r_reg.irs;
      rd_data[CRX_BIT] = r_reg.crx;
    end
    else
      rd_hit = 1'b0;
    rd_rx = rd_go && (s_axi_araddr == OFF_RX);
    if (rd_go)
    begin
      r_next.rvalid = 1'b1;
      r_next.rdata = rd_data;
      r_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    // read side effects, before hardware sets
    if (rd_rx)
    begin
      r_next.ri = 1'b0;
      r_next.framing_error_flag = 1'b0;
      r_next.per = 1'b0;
    end
    if ((r_reg.mode == MODE_OFF) || !r_reg.re)
    begin
      r_next.ovr = 1'b0;
      r_next.framing_error_flag = 1'b0;
      r_next.per = 1'b0;
    end
    // transfer clock edges
    r_next.ext_prev = pins_q[1];
    if (r_reg.cksrc)
    begin
      edge_c = (pins_q[1] != r_reg.ext_prev);
      lead_c = (r_reg.ext_prev == idle_lvl);
    end
    else if (brg_tick)
    begin
      edge_c = 1'b1;
      lead_c = (r_reg.sclk == idle_lvl);
      r_next.sclk = ~r_reg.sclk;
    end
    sh_in = r_reg.msb ? {r_reg.sh[6:0], pins_q[0]} : {pins_q[0], r_reg.sh[7:1]};
    // frame sequencer
    case (r_reg.phase)
      PH_OFF:
      begin
        r_next.txbit = RST_LINE;
        if (sync_mode)
          r_next.phase = PH_IDLE;
      end
      PH_IDLE:
      begin
        r_next.txbit = RST_LINE;
        if (!sync_mode)
          r_next.phase = PH_OFF;
        else if (r_reg.te && !r_reg.ti)
        begin
          start_c = 1'b1;
          r_next.phase = PH_SHIFT;
          r_next.sh = r_reg.txbuf;
          r_next.ti = 1'b1;
          r_next.shift_register_empty_flag = 1'b0;
          r_next.bits = '0;
          r_next.tx_irq = !r_reg.irs;
        end
      end
      PH_SHIFT:
      begin
        drive_c = edge_c && lead_c;
        samp_c = edge_c && !lead_c;
        if (!sync_mode)
        begin
          r_next.phase = PH_OFF;
          r_next.shift_register_empty_flag = 1'b1;
        end
        else if (drive_c)
          r_next.txbit = r_reg.msb ? r_reg.sh[7] : r_reg.sh[0];
        else if (samp_c)
        begin
          r_next.sh = sh_in;
          r_next.bits = r_reg.bits + 3'h1;
          if ((r_reg.bits == OVR_BIT_IDX) && r_reg.re && r_next.ri)
            r_next.ovr = 1'b1;
          if (r_reg.bits == LAST_BIT)
          begin
            done_c = 1'b1;
            r_next.phase = PH_IDLE;
            r_next.shift_register_empty_flag = 1'b1;
            r_next.tx_irq = r_reg.irs;
            if (r_reg.re)
            begin
              store_c = 1'b1;
              r_next.rxbuf = sh_in;
              if (!r_next.ovr)
              begin
                r_next.ri = 1'b1;
                r_next.rx_irq = 1'b1;
              end
            end
          end
        end
      end
      default:
        r_next.phase = PH_OFF;
    endcase
    if (r_next.phase != PH_SHIFT)
      r_next.sclk = idle_lvl;
    // continuous receive re-arm and register writes
    if (rd_rx && r_reg.crx)
      r_next.ti = 1'b0;
    if (wr_go && r_next.wlane)
    begin
      if (r_next.awaddr == OFF_TX)
      begin
        r_next.txbuf = r_next.wdata;
        r_next.ti = 1'b0;
      end
      else if (r_next.awaddr == OFF_BRG)
        r_next.brg = r_next.wdata;
      else if (r_next.awaddr == OFF_MODE)
      begin
        r_next.mode = r_next.wdata[2:0];
        r_next.cksrc = r_next.wdata[CKSRC_BIT];
      end
      else if (r_next.awaddr == OFF_CTLA)
      begin
        r_next.divsel = r_next.wdata[1:0];
        r_next.od = r_next.wdata[OD_BIT];
        r_next.cpol = r_next.wdata[CPOL_BIT];
        r_next.msb = r_next.wdata[MSB_BIT];
      end
      else if (r_next.awaddr == OFF_CTLB)
      begin
        r_next.te = r_next.wdata[TE_BIT];
        r_next.re = r_next.wdata[RE_BIT];
      end
      else if (r_next.awaddr == OFF_SHARED_SERIAL_CONTROL)
      begin
        r_next.irs = r_next.wdata[IRS_BIT];
        r_next.crx = r_next.wdata[CRX_BIT];
      end
    end
    r_next.awready = !r_next.aw_have && !r_next.bvalid;
    r_next.wready = !r_next.w_have && !r_next.bvalid;
    r_next.arready = !r_next.rvalid;
    // pin drivers
    if (r_next.mode != MODE_SYNC)
    begin
      r_next.txd_o = RST_LINE;
      r_next.txd_oe = 1'b0;
    end
    else if (r_next.od)
    begin
      r_next.txd_o = 1'b0;
      r_next.txd_oe = !r_next.txbit;
    end
    else
    begin
      r_next.txd_o = r_next.txbit;
      r_next.txd_oe = 1'b1;
    end
    r_next.sclk_o = r_next.sclk;
    r_next.sclk_oe = (r_next.mode == MODE_SYNC) && !r_next.cksrc;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r_reg <= ST_RST;
    else
      r_reg <= r_next;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready = r_reg.wready;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign serial_data_out = r_reg.txd_o;
  assign serial_data_out_oe = r_reg.txd_oe;
  assign transfer_clock_pin_out = r_reg.sclk_o;
  assign transfer_clock_pin_oe = r_reg.sclk_oe;
  assign tx_irq_req = r_reg.tx_irq;
  assign rx_irq_req = r_reg.rx_irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_frame_len: assert property (done_c |-> r_reg.bits == 3'h7)
    else $error("frame ended at wrong bit count");
  chk_start_gate: assert property (start_c |=> r_reg.ti && !r_reg.shift_register_empty_flag
    && r_reg.phase == PH_SHIFT && r_reg.bits == 3'h0)
    else $error("start did not load the shifter");
  chk_rx_gate: assert property (store_c |-> r_reg.re)
    else $error("frame stored with receive disabled");
  chk_tx_req_early: assert property (start_c && !r_reg.irs |=> tx_irq_req)
    else $error("missing tx request at start");
  chk_tx_req_late: assert property (done_c && r_reg.irs |=> tx_irq_req
    && r_reg.shift_register_empty_flag)
    else $error("missing tx request at end");
  chk_rx_req: assert property (rx_irq_req |-> $past(store_c) && r_reg.ri)
    else $error("rx request without a stored frame");
  chk_overrun_set: assert property (samp_c && r_reg.bits == 3'h6 && r_reg.re
    && r_reg.ri && !rd_rx |=> r_reg.ovr)
    else $error("overrun not flagged");
  chk_overrun_quiet: assert property (store_c && r_reg.ovr |=> !rx_irq_req)
    else $error("rx request raised on overrun");
  chk_err_clear: assert property ((r_reg.mode == MODE_OFF || !r_reg.re)
    |=> !r_reg.ovr && !r_reg.framing_error_flag && !r_reg.per)
    else $error("error flags not cleared");
  chk_rx_read_clear: assert property (rd_rx && !store_c |=> !r_reg.ri)
    else $error("rx complete not cleared by read");
  chk_cont_rearm: assert property (rd_rx && r_reg.crx |=> !r_reg.ti)
    else $error("continuous receive did not re-arm");
  chk_idle_line: assert property (r_reg.phase == PH_IDLE && sync_mode
    && $past(r_reg.phase) != PH_SHIFT
    |-> (r_reg.od ? !serial_data_out_oe : serial_data_out && serial_data_out_oe))
    else $error("data line not idle high");

endmodule : ccs_channel

//--- src/ccs_pkg.sv
// constants shared by the clocked serial channel design
// assumes a single aclk domain; offsets are AXI4-Lite byte addresses
package ccs_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_TX = 8'h00;
  localparam logic [7:0] OFF_RX = 8'h04;
  localparam logic [7:0] OFF_BRG = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0C;
  localparam logic [7:0] OFF_CTLA = 8'h10;
  localparam logic [7:0] OFF_CTLB = 8'h14;
  localparam logic [7:0] OFF_SHARED_SERIAL_CONTROL = 8'h18;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CKSRC_BIT = 3;
  localparam int SHIFT_REGISTER_EMPTY_FLAG_BIT = 3;
  localparam int OD_BIT = 5;
  localparam int CPOL_BIT = 6;
  localparam int MSB_BIT = 7;
  localparam int TE_BIT = 0;
  localparam int TI_BIT = 1;
  localparam int RE_BIT = 2;
  localparam int RI_BIT = 3;
  localparam int IRS_BIT = 0;
  localparam int CRX_BIT = 2;
  localparam int OVR_BIT = 12;
  localparam int FER_BIT = 13;
  localparam int PER_BIT = 14;
  localparam int SUM_BIT = 15;

  // ------------------------------------------------------------
  // encodings and counts
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SYNC = 3'h1;
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F8 = 2'h1;
  localparam logic [2:0] PRE8_LAST = 3'h7;
  localparam logic [4:0] PRE32_LAST = 5'h1F;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] OVR_BIT_IDX = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic RST_TI = 1'b1;
  localparam logic RST_SHIFT_REGISTER_EMPTY_FLAG = 1'b1;
  localparam logic RST_LINE = 1'b1;

  typedef enum logic [1:0]
  {
    PH_OFF = 2'b00,
    PH_IDLE = 2'b01,
    PH_SHIFT = 2'b11
  } ccs_phase_e;

endpackage : ccs_pkg

//--- src/ccs_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous inputs; output is a settled level in aclk
module ccs_sync3
  import ccs_pkg::*;
#(
  parameter int W = 2
)
(
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // pins
  input logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ccs_sync_s;

  ccs_sync_s r_reg;
  ccs_sync_s r_next;
  logic [W-1:0] agree;

  // ------------------------------------------------------------
  // level accepted once stages two and three agree
  // ------------------------------------------------------------
  always_comb
  begin
    agree = ~(r_reg.s2 ^ r_reg.s3);
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.lvl = (agree & r_reg.s3) | (~agree & r_reg.lvl);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign q = r_reg.lvl;

endmodule : ccs_sync3

//--- src/ccs_brg.sv
// prescaler and bit-rate divider for the transfer clock
// assumes run is held for the whole frame; tick marks a half period
module ccs_brg
  import ccs_pkg::*;
(
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // control
  input logic run,
  input logic [1:0] src_sel,
  input logic [7:0] divisor,
  // half-period strobe
  output logic tick
);

  typedef struct packed {
    logic [4:0] pre;
    logic [7:0] cnt;
    logic tick;
  } ccs_brg_s;

  ccs_brg_s r_reg;
  ccs_brg_s r_next;
  logic pre_tick;

  // ------------------------------------------------------------
  // f1 / f8 / f32 then divide by n+1 per half period
  // ------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.pre = r_reg.pre + 5'h01;
    r_next.tick = 1'b0;
    if (src_sel == SRC_F1)
      pre_tick = 1'b1;
    else if (src_sel == SRC_F8)
      pre_tick = (r_reg.pre[2:0] == PRE8_LAST);
    else
      pre_tick = (r_reg.pre == PRE32_LAST);
    if (!run)
      r_next.cnt = '0;
    else if (pre_tick)
    begin
      if (r_reg.cnt == divisor)
      begin
        r_next.cnt = '0;
        r_next.tick = 1'b1;
      end
      else
        r_next.cnt = r_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign tick = r_reg.tick;

endmodule : ccs_brg

//--- verification/ccs_peer.sv
// synchronous serial peer for the channel bench
// assumes sck is the resolved clock wire and sdo idles high by pull-up
module ccs_peer
(
  // link
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  // setup
  input wire logic cpol,
  input wire logic msb,
  input wire logic arm,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  int i = 0;
  int j = 0;
  initial sdi = 1'b1;
  initial rx_byte = 8'h00;
  always @(posedge arm)
  begin
    i = 0;
    j = 0;
  end
  // drive on one edge, sample on the other
  always @(sck)
  begin
    if (sck === cpol)
    begin
      if (i < 8) sdi <= tx_byte[msb ? 7 - i : i];
      i++;
    end
    else
    begin
      rx_byte <= msb ? {rx_byte[6:0], sdo} : {sdo, rx_byte[7:1]};
      j++;
      if (j == 8) sdi <= #100 ~sdi;
    end
  end
endmodule : ccs_peer

//--- verification/clocked_serial_channel_test.sv
// self-checking bench for the clocked serial channel
// assumes ccs_pkg, ccs_channel and ccs_peer are compiled first
module clocked_serial_channel_test
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic ext_ck = 1'b1, p_cpol = 1'b0, p_msb = 1'b0, arm = 1'b0, pck = 1'b1;
  logic [7:0] p_tx = 8'h00;
  wire awr, wr_rdy, bv, arr, rv, sdo_q, sdo_oe, ck_o, ck_oe, txq, rxq, sdi;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [7:0] p_rx;
  wire sck = ck_oe ? ck_o : ext_ck;
  wire sdo = sdo_oe ? sdo_q : 1'b1;
  int err_count = 0, n_compared = 0, cyc = 0, last = 0, half = 0;
  int tx_n = 0, rx_n = 0, tx_t = 0, rx_t = 0;
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (txq === 1'b1) begin tx_n <= tx_n + 1; tx_t <= cyc; end
    if (rxq === 1'b1) begin rx_n <= rx_n + 1; rx_t <= cyc; end
    if (ck_o !== pck) begin pck <= ck_o; half <= cyc - last; last <= cyc; end
  end
  ccs_channel dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rr), .serial_data_out(sdo_q),
    .serial_data_out_oe(sdo_oe), .serial_data_in(sdi), .transfer_clock_pin_in(sck),
    .transfer_clock_pin_out(ck_o), .transfer_clock_pin_oe(ck_oe), .tx_irq_req(txq),
    .rx_irq_req(rxq));
  ccs_peer peer (.sck(sck), .sdo(sdo), .sdi(sdi), .cpol(p_cpol), .msb(p_msb), .arm(arm),
    .tx_byte(p_tx), .rx_byte(p_rx));
  // ------------------------------------------------------------
  // bus and helper tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= {24'h0, d}; bry <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    bry <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arv <= 1'b1; ara <= a; rry <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdat;
    r = rr;
    rry <= 1'b0;
  endtask : rdr
  task automatic wait_chg(input int s, input bit rx);
    int k;
    k = 0;
    while ((rx ? rx_n : tx_n) == s && k < 4000)
    begin
      @(posedge aclk);
      k++;
    end
    if (k >= 4000)
    begin
      err_count++;
      finish_test;
    end
    repeat (2) @(posedge aclk);
  endtask : wait_chg
  task automatic rearm;
    repeat (8) @(posedge aclk);
    arm <= 1'b1;
    @(posedge aclk);
    arm <= 1'b0;
  endtask : rearm
  task automatic cfg(input logic [1:0] src, input logic [7:0] n, input logic pol, msb, irs,
    ext, crx, input logic [7:0] ctlb);
    wr(OFF_MODE, {4'h0, ext, MODE_SYNC});
    wr(OFF_CTLA, {msb, pol, 4'h0, src});
    wr(OFF_BRG, n);
    wr(OFF_SHARED_SERIAL_CONTROL, {5'h0, crx, 1'b0, irs});
    wr(OFF_CTLB, ctlb);
    p_cpol <= pol; p_msb <= msb; ext_ck <= ~pol;
    rearm;
  endtask : cfg
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d; logic [1:0] r;
    `CHK({sdo_q, sdo_oe, ck_o, ck_oe}, 4'hA)
    rdr(OFF_CTLB, d, r); `CHK(d, 32'h2)
    rdr(OFF_CTLA, d, r); `CHK(d, 32'h8)
    rdr(8'h1C, d, r); `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(8'h1C, 8'hFF); `CHK(br, RESP_SLVERR)
    wr(OFF_MODE, {5'h0, MODE_SYNC}); repeat (4) @(posedge aclk);
    `CHK(br, RESP_OKAY)
    `CHK({sdo_q, sdo_oe, ck_oe}, 3'h7)
    wr(OFF_CTLA, 8'h20); repeat (4) @(posedge aclk);
    `CHK(sdo_oe, 1'b0)
  endtask : t_reset
  task automatic frame(input logic [1:0] src, input logic [7:0] n, input logic pol, msb,
    irs, ext, input logic [7:0] v);
    logic [31:0] d; logic [1:0] r; int t0, r0;
    cfg(src, n, pol, msb, irs, ext, 1'b0, 8'h05);
    p_tx <= ~v; t0 = tx_n; r0 = rx_n;
    wr(OFF_TX, v);
    if (ext) repeat (16) begin repeat (32) @(posedge aclk); ext_ck <= ~ext_ck; end
    wait_chg(r0, 1'b1);
    `CHK(p_rx, v)
    `CHK(tx_n - t0, 1)
    `CHK(irs ? tx_t === rx_t : tx_t < rx_t, 1'b1)
    if (ext) `CHK(ck_oe, 1'b0)
    else `CHK(half, (src == SRC_F1 ? 1 : src == SRC_F8 ? 8 : 32) * (int'(n) + 1))
    rdr(OFF_RX, d, r); `CHK(d[12:0], {5'h0, ~v})
    rdr(OFF_CTLB, d, r); `CHK(d[3:0], 4'h7)
  endtask : frame
  task automatic t_gate;
    logic [31:0] d; logic [1:0] r; int t0, r0;
    cfg(SRC_F1, 8'h0F, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h04);
    t0 = tx_n; r0 = rx_n;
    wr(OFF_TX, 8'h66);
    repeat (300) @(posedge aclk);
    `CHK(tx_n - t0, 0)
    rdr(OFF_CTLB, d, r); `CHK(d[1], 1'b0)
    wr(OFF_CTLB, 8'h01);
    wait_chg(t0, 1'b0);
    `CHK(rx_n - r0, 0)
    `CHK(tx_n - t0, 1)
  endtask : t_gate
  task automatic t_ovr;
    logic [31:0] d; logic [1:0] r; int t0, r0;
    cfg(SRC_F1, 8'h0F, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h05);
    r0 = rx_n;
    wr(OFF_TX, 8'h11); wait_chg(r0, 1'b1);
    rearm; t0 = tx_n;
    wr(OFF_TX, 8'h22); wait_chg(t0, 1'b0);
    `CHK(rx_n - r0, 1)
    rdr(OFF_RX, d, r); `CHK(d[12], 1'b1)
    wr(OFF_CTLB, 8'h01);
    rdr(OFF_RX, d, r); `CHK(d[15:12], 4'h0)
  endtask : t_ovr
  task automatic t_crx;
    logic [31:0] d; logic [1:0] r; int r0;
    cfg(SRC_F1, 8'h0F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h05);
    r0 = rx_n;
    rdr(OFF_RX, d, r);
    wait_chg(r0, 1'b1);
    `CHK(rx_n - r0, 1)
  endtask : t_crx
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    frame(SRC_F1, 8'h0F, 1'b0, 1'b0, 1'b0, 1'b0, 8'hA5);
    frame(SRC_F8, 8'h01, 1'b1, 1'b1, 1'b1, 1'b0, 8'h3C);
    frame(2'h2, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 8'h81);
    frame(SRC_F1, 8'h0F, 1'b1, 1'b0, 1'b0, 1'b1, 8'h5E);
    t_gate;
    t_ovr;
    t_crx;
    finish_test;
  end
  initial
  begin
    repeat (40000) @(posedge aclk);
    err_count++;
    finish_test;
  end
endmodule : clocked_serial_channel_test
